// File: design/standby_ctrl.sv
// Standby controller: light sleep on halt, deep sleep on stop, wake on
// an unmasked interrupt request, crystal stabilisation wait on wake from deep sleep.
// Assumes halt_exec and stop_exec are one-cycle pulses from the core and
// wake_request is the OR of all request flags whose mask flag is 0.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns

// Functional notes
// - Halt instruction enters light sleep and gates the CPU clock off.
// - In light sleep the running high-speed oscillator keeps oscillating.
// - Stop instruction enters deep sleep, halting both high-speed oscillators.
// - An interrupt request ends deep sleep.
// - Crystal source waits out a stabilisation count after deep sleep.
// - Registers, flags and data memory hold their contents while asleep.
// - Port output latches and buffer states stay unchanged while asleep.
// - Light sleep works from internal, crystal or external main clock.
// - Halt is ignored while an unmasked interrupt request is pending.
// - Slow oscillator runs asleep if timer select, or watchdog enabled with standby-run.
// - Main source feeding the CPU keeps running except in deep sleep; others stay off.
// - An unmasked interrupt request ends light sleep.
// - Watchdog stops asleep unless its standby-run bit is 1.
module standby_ctrl
  import standby_pkg::*;
#(
  parameter int unsigned STAB_UNIT = 256
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic wake_request,
  input wire axi_req_t axi_req,
  output axi_rsp_t axi_rsp,
  output clk_ctl_t clk_ctl
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic [1:0] src_sel;
    logic wakeup_timer_clock_select;
    logic watchdog_standby_run;
    logic watchdog_enable_option;
    logic [2:0] stabilization_time_select;
    logic [CNT_W-1:0] stab_cnt;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic w_lane0;
    axi_rsp_t rsp;
    clk_ctl_t ctl;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic asleep_d;

  assign axi_rsp = s_q.rsp;
  assign clk_ctl = s_q.ctl;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [32:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input st_t s);
    logic [31:0] w;
    logic err;
    w = 32'h0000_0000;
    err = 1'b0;
    case (a)
      OFS_SPEED_MODE_CTRL: begin
        w[POS_SRC_SEL +: 2] = s.src_sel;
        w[POS_WUT_CLK_SEL] = s.wakeup_timer_clock_select;
      end
      OFS_OPTION: begin
        w[POS_WDT_STBY_RUN] = s.watchdog_standby_run;
        w[POS_WDT_ENABLE] = s.watchdog_enable_option;
      end
      OFS_STAB_SEL: w[POS_STAB_SEL +: 3] = s.stabilization_time_select;
      OFS_MODE_STATUS: w[3:0] = s.mode;
      OFS_STAB_COUNT: w[CNT_W-1:0] = s.stab_cnt;
      default: err = 1'b1;
    endcase
    return {err, w};
  endfunction : rd_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] rd;
    rd = 33'h0_0000_0000;
    s_d = s_q;
    s_d.ctl.cpu_resume = 1'b0;

    // Write channel: address and data taken in either order
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_lane0 = axi_req.wstrb[0];
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_d.aw_got && s_d.w_got && !s_q.rsp.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = RESP_OKAY;
      // All fields live in byte lane 0; other lanes are ignored
      case (s_d.aw_addr)
        OFS_SPEED_MODE_CTRL: begin
          if (s_d.w_lane0) begin
            s_d.src_sel = s_d.w_data[POS_SRC_SEL +: 2];
            s_d.wakeup_timer_clock_select = s_d.w_data[POS_WUT_CLK_SEL];
          end
        end
        OFS_OPTION: begin
          if (s_d.w_lane0) begin
            s_d.watchdog_standby_run = s_d.w_data[POS_WDT_STBY_RUN];
            s_d.watchdog_enable_option = s_d.w_data[POS_WDT_ENABLE];
          end
        end
        OFS_STAB_SEL: begin
          if (s_d.w_lane0) begin
            s_d.stabilization_time_select = s_d.w_data[POS_STAB_SEL +: 3];
          end
        end
        OFS_MODE_STATUS, OFS_STAB_COUNT: begin
        end
        default: s_d.rsp.bresp = RESP_SLVERR;
      endcase
    end
    s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;

    // Read channel: one read at a time
    if (axi_req.arvalid && s_q.rsp.arready) begin
      rd = rd_word(axi_req.araddr, s_q);
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rdata = rd[31:0];
      s_d.rsp.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // Sleep sequencing
    case (s_q.mode)
      MODE_RUN: begin
        if (stop_exec) begin
          s_d.mode = MODE_STOP;
        end else if (halt_exec && !wake_request) begin
          s_d.mode = MODE_HALT;
        end
      end
      MODE_HALT: begin
        if (wake_request) begin
          s_d.mode = MODE_RUN;
          s_d.ctl.cpu_resume = 1'b1;
        end
      end
      MODE_STOP: begin
        if (wake_request) begin
          // Only the crystal needs time to settle after restart
          if (s_q.src_sel == SRC_CRYSTAL) begin
            s_d.mode = MODE_STAB;
            s_d.stab_cnt = CNT_W'(STAB_UNIT) << s_q.stabilization_time_select;
          end else begin
            s_d.mode = MODE_RUN;
            s_d.ctl.cpu_resume = 1'b1;
          end
        end
      end
      MODE_STAB: begin
        if (s_q.stab_cnt <= CNT_W'(1)) begin
          s_d.stab_cnt = '0;
          s_d.mode = MODE_RUN;
          s_d.ctl.cpu_resume = 1'b1;
        end else begin
          s_d.stab_cnt = s_q.stab_cnt - CNT_W'(1);
        end
      end
      default: s_d.mode = MODE_RUN;
    endcase

    // Clock and hold outputs follow the next mode
    asleep_d = (s_d.mode == MODE_HALT) || (s_d.mode == MODE_STOP);
    s_d.ctl.cpu_clk_en = (s_d.mode == MODE_RUN);
    // Selected main source stays on in run and light sleep; the crystal also stays on in the stabilisation wait
    s_d.ctl.fast_internal_osc_clock_run = (s_d.src_sel == SRC_FAST_INT) &&
        (s_d.mode == MODE_RUN || s_d.mode == MODE_HALT);
    s_d.ctl.crystal_osc_clock_run = (s_d.src_sel == SRC_CRYSTAL) &&
        (s_d.mode != MODE_STOP);
    s_d.ctl.external_main_clock_run = (s_d.src_sel == SRC_EXT_CLK) &&
        (s_d.mode == MODE_RUN || s_d.mode == MODE_HALT);
    s_d.ctl.slow_internal_osc_clock_run = !asleep_d ||
        s_d.wakeup_timer_clock_select ||
        (s_d.watchdog_enable_option && s_d.watchdog_standby_run);
    s_d.ctl.watchdog_count_en = s_d.watchdog_enable_option &&
        (!asleep_d || s_d.watchdog_standby_run);
    // Hold freezes core registers, memory and port latches; no reset
    s_d.ctl.state_hold = (s_d.mode != MODE_RUN);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mode <= MODE_RUN;
      s_q.src_sel <= RST_SRC_SEL;
      s_q.wakeup_timer_clock_select <= RST_WUT_CLK_SEL;
      s_q.watchdog_standby_run <= RST_WDT_STBY_RUN;
      s_q.watchdog_enable_option <= RST_WDT_ENABLE;
      s_q.stabilization_time_select <= RST_STAB_SEL;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
      s_q.ctl.cpu_clk_en <= 1'b1;
      s_q.ctl.fast_internal_osc_clock_run <= 1'b1;
      s_q.ctl.slow_internal_osc_clock_run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic run_q;
  logic sleep_q;
  assign run_q = (s_q.mode == MODE_RUN);
  assign sleep_q = (s_q.mode == MODE_HALT) || (s_q.mode == MODE_STOP);

  AST_HALT_ENTRY: assert property (
    run_q && halt_exec && !stop_exec && !wake_request |=>
      s_q.mode == MODE_HALT && !s_q.ctl.cpu_clk_en && s_q.ctl.state_hold)
    else $error("halt did not enter light sleep");
  AST_HALT_OSC: assert property (
    s_q.mode == MODE_HALT |->
      s_q.ctl.fast_internal_osc_clock_run == (s_q.src_sel == SRC_FAST_INT) &&
      s_q.ctl.crystal_osc_clock_run == (s_q.src_sel == SRC_CRYSTAL))
    else $error("main oscillator wrong in light sleep");
  AST_STOP_OSC: assert property (
    s_q.mode == MODE_STOP |-> !s_q.ctl.fast_internal_osc_clock_run &&
      !s_q.ctl.crystal_osc_clock_run && !s_q.ctl.external_main_clock_run)
    else $error("high-speed oscillator running in deep sleep");
  AST_STOP_WAKE: assert property (
    s_q.mode == MODE_STOP && wake_request |=> s_q.mode != MODE_STOP)
    else $error("deep sleep not left on request");
  AST_STAB_STEP: assert property (
    s_q.mode == MODE_STAB && s_q.stab_cnt > CNT_W'(1) |=>
      s_q.mode == MODE_STAB && s_q.stab_cnt == $past(s_q.stab_cnt) - CNT_W'(1)
      && !s_q.ctl.cpu_clk_en)
    else $error("stabilisation count did not step");
  AST_HOLD: assert property (
    !run_q |-> s_q.ctl.state_hold && !s_q.ctl.cpu_clk_en)
    else $error("state not held while asleep");
  AST_HALT_REFUSE: assert property (
    run_q && halt_exec && !stop_exec && wake_request |=> run_q)
    else $error("halt taken with request pending");
  AST_SLOW_OSC: assert property (
    sleep_q |-> s_q.ctl.slow_internal_osc_clock_run ==
      (s_q.wakeup_timer_clock_select ||
       (s_q.watchdog_enable_option && s_q.watchdog_standby_run)))
    else $error("slow oscillator state wrong asleep");
  AST_HALT_WAKE: assert property (
    s_q.mode == MODE_HALT && wake_request |=>
      run_q && s_q.ctl.cpu_clk_en && s_q.ctl.cpu_resume ##1 !s_q.ctl.cpu_resume)
    else $error("light sleep not left on request");
  AST_WDT: assert property (
    sleep_q |-> s_q.ctl.watchdog_count_en ==
      (s_q.watchdog_enable_option && s_q.watchdog_standby_run))
    else $error("watchdog run state wrong asleep");
  AST_BRESP: assert property (
    s_q.rsp.bvalid && !axi_req.bready |=> s_q.rsp.bvalid &&
      $stable(s_q.rsp.bresp))
    else $error("write response dropped");

  COV_HALT_CYCLE: cover property (
    s_q.mode == MODE_HALT ##[1:20] s_q.ctl.cpu_resume);
  COV_STOP_XTAL: cover property (
    s_q.mode == MODE_STOP ##1 s_q.mode == MODE_STAB);
  COV_HALT_REFUSED: cover property (run_q && halt_exec && wake_request);
  COV_STAB_DONE: cover property (s_q.mode == MODE_STAB ##1 run_q);

endmodule : standby_ctrl

// File: design/standby_pkg.sv
// Package for the standby controller: register map, field layout,
// reset values, mode encoding and the bus and clock-control carriers.
// Assumes a 32-bit AXI4-Lite master with an 8-bit byte address.
package standby_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int CNT_W = 24;
  localparam logic [7:0] OFS_SPEED_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPTION = 8'h04;
  localparam logic [7:0] OFS_STAB_SEL = 8'h08;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h0C;
  localparam logic [7:0] OFS_STAB_COUNT = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_SRC_SEL = 0;
  localparam int POS_WUT_CLK_SEL = 4;
  localparam int POS_WDT_STBY_RUN = 0;
  localparam int POS_WDT_ENABLE = 4;
  localparam int POS_STAB_SEL = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SRC_SEL = 2'h0;
  localparam logic RST_WUT_CLK_SEL = 1'b0;
  localparam logic RST_WDT_STBY_RUN = 1'b0;
  localparam logic RST_WDT_ENABLE = 1'b0;
  localparam logic [2:0] RST_STAB_SEL = 3'h7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_FAST_INT = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_EXT_CLK = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_RUN = 4'h1,
    MODE_HALT = 4'h2,
    MODE_STOP = 4'h4,
    MODE_STAB = 4'h8
  } mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic fast_internal_osc_clock_run;
    logic crystal_osc_clock_run;
    logic external_main_clock_run;
    logic slow_internal_osc_clock_run;
    logic watchdog_count_en;
    logic state_hold;
    logic cpu_resume;
  } clk_ctl_t;

endpackage : standby_pkg

// File: sim/tb_top.sv
// Testbench for the standby controller: bus, sleep and wake tasks.
// Assumes standby_pkg and standby_ctrl are compiled first.
`timescale 1ns/1ns
module tb_top;
  import standby_pkg::*;
  // Short unit keeps the crystal wait to a handful of cycles
  localparam int unsigned UNIT = 2;
  localparam int unsigned N = UNIT << 1;
  logic ref_clk;
  logic nrst;
  logic halt_exec;
  logic stop_exec;
  logic wake_request;
  axi_req_t req;
  axi_rsp_t rsp;
  clk_ctl_t ctl;
  int err_count;
  int checked;
  logic [31:0] rd;
  logic [1:0] resp;

  standby_ctrl #(.STAB_UNIT(UNIT)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .wake_request(wake_request),
    .axi_req(req), .axi_rsp(rsp), .clk_ctl(ctl)
  );

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp,
                input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word

  // Bits: cpu, fast, crystal, ext, slow, watchdog, hold, resume
  task chk_ctl(input logic [7:0] exp);
    chk_word({24'h0, ctl}, {24'h0, exp}, "clock control");
  endtask : chk_ctl

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 output logic [1:0] r);
    logic done;
    @(posedge ref_clk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    done = 1'h0;
    r = 2'h3;
    // Only the bench watchdog ends a wait that never gets its answer
    while (!done) begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
    logic done;
    @(posedge ref_clk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    done = 1'h0;
    d = 32'h0;
    r = 2'h3;
    while (!done) begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : axi_read

  // ----------------------------------------------------------------
  // Sleep and wake
  // ----------------------------------------------------------------
  task enter_sleep(input logic deep, input logic [7:0] exp);
    @(posedge ref_clk);
    halt_exec <= ~deep;
    stop_exec <= deep;
    @(posedge ref_clk);
    halt_exec <= 1'h0;
    stop_exec <= 1'h0;
    @(negedge ref_clk);
    chk_ctl(exp);
  endtask : enter_sleep

  // Request is held for exactly one sampling edge
  task do_wake(input logic [7:0] exp);
    @(posedge ref_clk);
    wake_request <= 1'h1;
    @(posedge ref_clk);
    wake_request <= 1'h0;
    @(negedge ref_clk);
    chk_ctl(exp);
  endtask : do_wake

  task print_verdict;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'h0;
    halt_exec = 1'h0;
    stop_exec = 1'h0;
    wake_request = 1'h0;
    req = '0;
    err_count = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'h1;
    @(negedge ref_clk);
    chk_ctl(8'hC8);
    axi_read(OFS_STAB_SEL, rd, resp);
    chk_word(rd, {29'h0, RST_STAB_SEL}, "select reset");
    axi_read(8'h14, rd, resp);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_write(8'h14, 32'hFF, resp);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_write(OFS_OPTION, 32'h11, resp);
    @(negedge ref_clk);
    chk_ctl(8'hCC);
    // Pending request blocks light sleep
    @(posedge ref_clk);
    wake_request <= 1'h1;
    enter_sleep(1'h0, 8'hCC);
    @(posedge ref_clk);
    wake_request <= 1'h0;
    axi_read(OFS_MODE_STATUS, rd, resp);
    chk_word(rd, {28'h0, MODE_RUN}, "run after refused halt");
    enter_sleep(1'h0, 8'h4E);
    axi_read(OFS_MODE_STATUS, rd, resp);
    chk_word(rd, {28'h0, MODE_HALT}, "halt status");
    do_wake(8'hCD);
    @(negedge ref_clk);
    chk_ctl(8'hCC);
    axi_read(OFS_OPTION, rd, resp);
    chk_word(rd, 32'h11, "retained option");
    // Crystal source, watchdog enabled but stopped in standby
    axi_write(OFS_OPTION, 32'h10, resp);
    axi_write(OFS_SPEED_MODE_CTRL, {30'h0, SRC_CRYSTAL}, resp);
    @(negedge ref_clk);
    chk_ctl(8'hAC);
    enter_sleep(1'h0, 8'h22);
    do_wake(8'hAD);
    // External clock with wake-up timer select
    axi_write(OFS_SPEED_MODE_CTRL, {27'h0, 1'h1, 2'h0, SRC_EXT_CLK}, resp);
    enter_sleep(1'h0, 8'h1A);
    do_wake(8'h9D);
    // Deep sleep from crystal with a stabilisation wait
    axi_write(OFS_OPTION, 32'h0, resp);
    axi_write(OFS_SPEED_MODE_CTRL, {30'h0, SRC_CRYSTAL}, resp);
    axi_write(OFS_STAB_SEL, 32'h1, resp);
    // No crystal peripheral or converter runs in this bench before stop
    enter_sleep(1'h1, 8'h02);
    do_wake(8'h2A);
    repeat (N - 1) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_ctl(8'h2A);
    @(negedge ref_clk);
    chk_ctl(8'hA9);
    // Deep sleep from internal source resumes at once
    axi_write(OFS_SPEED_MODE_CTRL, {30'h0, SRC_FAST_INT}, resp);
    enter_sleep(1'h1, 8'h02);
    do_wake(8'hC9);
    print_verdict();
  end

  initial begin
    #200000;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_top
